// File: hdl/adcrc_pkg.sv
// Package for the converter result and compare control block.
// Assumes one 25 MHz clock and a plain register port with 8-bit addresses.
package adcrc_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam logic [7:0] OFF_MODE0 = 8'h00;
	localparam logic [7:0] OFF_CHSEL = 8'h01;
	localparam logic [7:0] OFF_CMPMODE = 8'h02;
	localparam logic [7:0] OFF_THRESH = 8'h03;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h05;
	localparam logic [7:0] OFF_RESULT_BASE = 8'h10;
	// Result of channel n: low byte at base+2n, high byte at base+2n+1
	localparam int unsigned MODE0_CE_BIT = 7;
	localparam int unsigned MODE0_SCAN_BIT = 6;
	localparam int unsigned CMP_EN_BIT = 7;
	localparam int unsigned CMP_COND_BIT = 6;
	localparam int unsigned CHSEL_W = 4;
	localparam logic [7:0] MODE0_RST = 8'h00;
	localparam logic [7:0] CHSEL_RST = 8'h00;
	localparam logic [7:0] CMPMODE_RST = 8'h00;
	localparam logic [7:0] THRESH_RST = 8'h00;
	localparam int unsigned IRQ_END_BIT = 0;
	localparam int unsigned IRQ_UNDEF_BIT = 1;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} adcrc_bus_s;

	typedef struct packed {
		logic valid;
		logic [3:0] chan;
		logic [9:0] data;
		logic last;
	} adcrc_conv_s;
endpackage

// File: hdl/adcrc_top.sv
// Converter control: registers, result store, threshold compare, irq.
// Assumes the analog sequencer delivers one finished result per pulse.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adcrc_top
	import adcrc_pkg::*;
#(
	parameter int unsigned NCHAN = 8
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire adcrc_bus_s bus,
	output logic [7:0] rdata,
	input wire adcrc_conv_s conv,
	output logic conv_enable,
	output logic scan_mode,
	output logic [CHSEL_W-1:0] chan_sel,
	output logic conversion_end_irq
);
	localparam int unsigned RW = 2 * NCHAN;

	logic [7:0] mode_reg_zero_q, mode_reg_zero_d;
	logic [7:0] channel_select_reg_q, channel_select_reg_d;
	logic [7:0] compare_mode_reg_q, compare_mode_reg_d;
	logic [7:0] compare_threshold_reg_q, compare_threshold_reg_d;
	logic [1:0] irq_stat_q, irq_stat_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	logic [9:0] channel_result_reg_q [NCHAN];
	logic [9:0] channel_result_reg_d [NCHAN];
	logic [NCHAN-1:0] undef_q, undef_d;
	logic [7:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic cmp_hit, store, raise_end, cfg_wr;
	logic [7:0] res_off;
	logic [$clog2(NCHAN)-1:0] res_idx;
	logic res_hit;

	function automatic logic is_wr(input adcrc_bus_s b,
		input logic [7:0] off);
		return b.wr && (b.addr == off);
	endfunction

	// Low byte holds the two low bits, left-justified
	function automatic logic [7:0] result_byte(input logic [9:0] r,
		input logic hi);
		if (hi) begin
			return r[9:2];
		end
		return {r[1:0], 6'h00};
	endfunction

	// Condition bit set: at or above threshold; clear: below
	always_comb begin
		if (compare_mode_reg_q[CMP_COND_BIT]) begin
			cmp_hit = (conv.data[9:2] >= compare_threshold_reg_q);
		end else begin
			cmp_hit = (conv.data[9:2] < compare_threshold_reg_q);
		end
	end

	always_comb begin
		store = 1'b0;
		raise_end = 1'b0;
		if (conv.valid) begin
			if (!compare_mode_reg_q[CMP_EN_BIT]) begin
				store = 1'b1;
				raise_end = mode_reg_zero_q[MODE0_SCAN_BIT] ? conv.last : 1'b1;
			end else if (!mode_reg_zero_q[MODE0_SCAN_BIT]) begin
				store = cmp_hit;
				raise_end = cmp_hit;
			end else if (conv.chan == 4'h0) begin
				store = cmp_hit;
				raise_end = cmp_hit;
			end else begin
				// Other channels always land; end of scan stays silent
				store = 1'b1;
				raise_end = 1'b0;
			end
		end
	end

	// Either write may disturb a result the sequencer is filling
	assign cfg_wr = is_wr(bus, OFF_MODE0) || is_wr(bus, OFF_CHSEL);

	always_comb begin
		mode_reg_zero_d = mode_reg_zero_q;
		channel_select_reg_d = channel_select_reg_q;
		compare_mode_reg_d = compare_mode_reg_q;
		compare_threshold_reg_d = compare_threshold_reg_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		undef_d = undef_q;
		if (is_wr(bus, OFF_MODE0)) begin
			mode_reg_zero_d = bus.wdata;
		end
		// Upper bits are reserved; dropping them keeps the mux in range
		if (is_wr(bus, OFF_CHSEL)) begin
			channel_select_reg_d = {4'h0, bus.wdata[3:0]};
		end
		// Writes land even while converting; software must stop first
		if (is_wr(bus, OFF_CMPMODE)) begin
			compare_mode_reg_d = bus.wdata;
		end
		if (is_wr(bus, OFF_THRESH)) begin
			compare_threshold_reg_d = bus.wdata;
		end
		if (is_wr(bus, OFF_IRQ_MASK)) begin
			irq_mask_d = bus.wdata[1:0];
		end
		if (is_wr(bus, OFF_IRQ_STAT)) begin
			irq_stat_d = irq_stat_q & ~bus.wdata[1:0];
		end
		// Config writes flag every result undefined, except one stored in the same cycle
		// Flag raised once per batch; later writes find flags pending
		if (cfg_wr) begin
			undef_d = '1;
			if (|undef_q == 1'b0) begin
				irq_stat_d[IRQ_UNDEF_BIT] = 1'b1;
			end
		end
		if (raise_end) begin
			irq_stat_d[IRQ_END_BIT] = 1'b1;
		end
		// Channels beyond the store are dropped, never aliased
		if (store && (int'(conv.chan) < NCHAN)) begin
			undef_d[conv.chan[$clog2(NCHAN)-1:0]] = 1'b0;
		end
	end

	generate
		for (genvar i = 0; i < NCHAN; i++) begin : g_res
			always_comb begin
				channel_result_reg_d[i] = channel_result_reg_q[i];
				if (store && (conv.chan == 4'(i))) begin
					channel_result_reg_d[i] = conv.data;
				end
			end
			always_ff @(posedge core_clk) begin
				if (srst) begin
					channel_result_reg_q[i] <= 10'h000;
				end else begin
					channel_result_reg_q[i] <= channel_result_reg_d[i];
				end
			end
		end
	endgenerate

	// Result window offset; the low bit picks the byte of a channel
	assign res_off = bus.addr - OFF_RESULT_BASE;
	assign res_idx = res_off[$clog2(NCHAN):1];
	assign res_hit = (bus.addr >= OFF_RESULT_BASE) &&
		(bus.addr < OFF_RESULT_BASE + 8'(RW));

	// Reads need a fast CPU clock; nothing here can check that
	always_comb begin
		rdata_d = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				OFF_MODE0: rdata_d = mode_reg_zero_q;
				OFF_CHSEL: rdata_d = channel_select_reg_q;
				OFF_CMPMODE: rdata_d = compare_mode_reg_q;
				OFF_THRESH: rdata_d = compare_threshold_reg_q;
				OFF_IRQ_STAT: rdata_d = {6'h00, irq_stat_q};
				OFF_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
				default: begin
					// Window base need not align to the channel count
					if (res_hit) begin
						rdata_d = result_byte(channel_result_reg_q[res_idx],
							res_off[0]);
					end
				end
			endcase
		end
	end

	// Next-state values save a cycle of interrupt latency
	assign irq_d = |(irq_stat_d & irq_mask_d);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode_reg_zero_q <= MODE0_RST;
			channel_select_reg_q <= CHSEL_RST;
			compare_mode_reg_q <= CMPMODE_RST;
			compare_threshold_reg_q <= THRESH_RST;
			irq_stat_q <= 2'h0;
			irq_mask_q <= 2'h0;
			undef_q <= '0;
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			mode_reg_zero_q <= mode_reg_zero_d;
			channel_select_reg_q <= channel_select_reg_d;
			compare_mode_reg_q <= compare_mode_reg_d;
			compare_threshold_reg_q <= compare_threshold_reg_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			undef_q <= undef_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	assign rdata = rdata_q;
	assign conversion_end_irq = irq_q;
	// Sequencer restarts on these; software gates changes via enable
	assign conv_enable = mode_reg_zero_q[MODE0_CE_BIT];
	assign scan_mode = mode_reg_zero_q[MODE0_SCAN_BIT];
	assign chan_sel = channel_select_reg_q[CHSEL_W-1:0];
endmodule
`default_nettype wire

// File: tb/adcrc_properties.sv
// Checker for the compare gating of the conversion end interrupt.
// Assumes binding to adcrc_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adcrc_properties
	import adcrc_pkg::*;
#(parameter int unsigned NCHAN = 8) (
	input wire logic core_clk,
	input wire logic srst,
	input wire adcrc_bus_s bus,
	input wire logic [7:0] rdata,
	input wire adcrc_conv_s conv,
	input wire logic conv_enable,
	input wire logic scan_mode,
	input wire logic [CHSEL_W-1:0] chan_sel,
	input wire logic conversion_end_irq
);
	logic [7:0] cmp_q, thr_q, msk_q;
	logic hit, on, qt;
	// Shadows of register state, since the ports hide it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmp_q <= 8'h00;
			thr_q <= 8'h00;
			msk_q <= 8'h00;
		end else if (bus.wr) begin
			if (bus.addr == OFF_CMPMODE) cmp_q <= bus.wdata;
			if (bus.addr == OFF_THRESH) thr_q <= bus.wdata;
			if (bus.addr == OFF_IRQ_MASK) msk_q <= bus.wdata;
		end
	end
	assign hit = cmp_q[CMP_COND_BIT] ? conv.data[9:2] >= thr_q
		: conv.data[9:2] < thr_q;
	assign on = conv.valid && cmp_q[CMP_EN_BIT];
	// A write or the unmasked invalid flag may raise the line on its own
	assign qt = !bus.wr && !msk_q[IRQ_UNDEF_BIT];
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_sel_hit;
		on && !scan_mode && hit && conv.chan == chan_sel && msk_q[0]
		|=> conversion_end_irq;
	endproperty
	a_sel_hit: assert property (p_sel_hit) else $error("no irq on hit");
	property p_sel_miss;
		on && !scan_mode && !hit && qt |=> !$rose(conversion_end_irq);
	endproperty
	a_sel_miss: assert property (p_sel_miss) else $error("irq on miss");
	property p_scan_miss;
		on && scan_mode && conv.chan == 4'h0 && !hit && qt
		|=> !$rose(conversion_end_irq);
	endproperty
	a_scan_miss: assert property (p_scan_miss) else $error("scan irq");
	property p_scan_hit;
		on && scan_mode && conv.chan == 4'h0 && hit && msk_q[IRQ_END_BIT]
		|=> conversion_end_irq;
	endproperty
	a_scan_hit: assert property (p_scan_hit) else $error("scan hit");
	property p_scan_end;
		on && scan_mode && conv.last && conv.chan != 4'h0 && qt
		|=> !$rose(conversion_end_irq);
	endproperty
	a_scan_end: assert property (p_scan_end) else $error("end irq");
	c_hit: cover property (on && hit);
	c_miss: cover property (on && scan_mode && !hit);
	c_end: cover property (on && scan_mode && conv.last);
endmodule
bind adcrc_top adcrc_properties #(.NCHAN(NCHAN)) u_props (
	.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
	.conv(conv), .conv_enable(conv_enable), .scan_mode(scan_mode),
	.chan_sel(chan_sel), .conversion_end_irq(conversion_end_irq));
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: register port, select and scan compare, interrupt.
// Assumes the checker is bound into the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top import adcrc_pkg::*;;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	adcrc_bus_s bus = '0;
	adcrc_conv_s conv = '0;
	logic [7:0] rdata;
	logic conv_enable, scan_mode, irq;
	logic [3:0] chan_sel;
	int errors = 0;
	int n_checks = 0;
	always #20 core_clk = ~core_clk;
	adcrc_top #(.NCHAN(8)) DUT (.core_clk(core_clk), .srst(srst),
		.bus(bus), .rdata(rdata), .conv(conv), .conv_enable(conv_enable),
		.scan_mode(scan_mode), .chan_sel(chan_sel),
		.conversion_end_irq(irq));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk) bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic cv(input logic [3:0] c, input logic [9:0] d, input logic l);
		@(posedge core_clk) conv <= '{1'b1, c, d, l};
		@(posedge core_clk) conv.valid <= 1'b0;
		@(posedge core_clk) #1;
	endtask
	task automatic cfg(input logic [7:0] m, c, cm, t);
		wr(OFF_MODE0, 8'h00);
		wr(OFF_CHSEL, c);
		wr(OFF_CMPMODE, cm);
		wr(OFF_THRESH, t);
		wr(OFF_MODE0, m);
		wr(OFF_IRQ_STAT, 8'h03);
	endtask
	task automatic t_sel();
		cfg(8'h80, 8'h02, 8'hc0, 8'h80);
		chk({conv_enable, scan_mode, 2'b00, chan_sel}, 8'h82);
		cv(4'h2, 10'h201, 1'b1);
		chk({7'h00, irq}, 8'h01);
		rd(8'h15, 8'h80);
		rd(8'h14, 8'h40);
		wr(OFF_IRQ_STAT, 8'h01);
		cv(4'h2, 10'h1fc, 1'b1);
		chk({7'h00, irq}, 8'h00);
		rd(8'h15, 8'h80);
		$display("t_sel done");
	endtask
	task automatic t_scan();
		cfg(8'hc0, 8'h00, 8'h80, 8'h10);
		cv(4'h0, 10'h020, 1'b0);
		chk({7'h00, irq}, 8'h01);
		wr(OFF_IRQ_STAT, 8'h01);
		cv(4'h0, 10'h080, 1'b0);
		chk({7'h00, irq}, 8'h00);
		cv(4'h1, 10'h3fe, 1'b1);
		chk({7'h00, irq}, 8'h00);
		rd(8'h11, 8'h08);
		rd(8'h13, 8'hff);
		rd(8'h0f, 8'h00);
		$display("t_scan done");
	endtask
	task automatic t_plain();
		cfg(8'hc0, 8'h00, 8'h00, 8'h00);
		cv(4'h0, 10'h3ff, 1'b0);
		chk({7'h00, irq}, 8'h00);
		cv(4'h1, 10'h004, 1'b1);
		chk({7'h00, irq}, 8'h01);
		rd(8'h11, 8'hff);
		rd(8'h13, 8'h01);
		$display("t_plain done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		#1 chk(rdata, 8'h00);
		wr(OFF_IRQ_MASK, 8'h01);
		wr(OFF_CHSEL, 8'h00);
		rd(OFF_IRQ_STAT, 8'h02);
		chk({7'h00, irq}, 8'h00);
		t_sel();
		t_scan();
		t_plain();
		end_sim();
	end
	initial begin
		#20000;
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
